// ---- ppl_defines.svh ----
// Constants for the parameter password lock block
`ifndef PPL_DEFINES_SVH
`define PPL_DEFINES_SVH
`define PPL_LVL_NONE   16'h270F
`define PPL_LVL_HUND   16'h0064
`define PPL_LVL_MAXLO  16'h0006
`define PPL_LVL_MINHI  16'h0065
`define PPL_LVL_MAXHI  16'h006A
`define PPL_PW_NONE    16'h270F
`define PPL_PW_MIN     16'h03E8
`define PPL_PW_MAX     16'h270E
`define PPL_ERR_MAX    3'h5
`define PPL_WS_STOP    2'h0
`define PPL_WS_NEVER   2'h1
`endif

// ---- ppl_host.sv ----
// Host model: panel or network side issuing one request at a time
module ppl_host
  import ppl_pkg::*;
(
  input  wire logic      clk,       // Control clock
  input  wire ppl_resp_t resp,      // Answer from the lock block
  output logic           req_valid, // Request strobe
  output ppl_req_t       req        // Request fields
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    req_valid = 1'b0;
    req = '0;
  end

  // One request: raised after a falling edge, held across the taking edge
  task automatic xfer(input ppl_op_t op, input ppl_kind_t kind, input ppl_src_t src,
                      input logic wr, input logic [15:0] wd, input logic ex,
                      output ppl_resp_t r);
    int n;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op: op, kind: kind, src: src, wr: wr, ext: ex, wdata: wd};
    @(negedge clk);
    req_valid = 1'b0;
    req.wdata = ~wd; // Stale data is inverted so it never passes for a value
    n = 0;
    // Answer may land one edge later; bounded wait
    while (resp.valid !== 1'b1 && n < 2) begin
      @(negedge clk);
      n++;
    end
    r = resp;
  endtask
endmodule // ppl_host

// ---- ppl_lock.sv ----
// Parameter password lock: access gate, lock level and password store
//
// Operation
// - Lock level takes 1..6 or 101..106; 9999 means no lock, reset value.
// - A password is a value 1000..9998; other values are refused.
// - Levels 1/101 block all writes, 2/102 panel writes, 3/103 network writes.
// - 4/104 block everything, 5/105 all panel access, 6/106 all network access.
// - Levels 1..6 read password as 0; 101..106 count errors 0..5.
// - After five errors the right password no longer unlocks; only all clear.
// - With a lock level set, password writes ignore extended display setting.
// - A registered password applies the level restriction until unlocked.
// - Once registered, password reads give only 0..5, never the password.
// - Writing the password while locked unlocks on match, else error.
// - All clear releases the lock and resets every parameter.
// - All clear is refused while the drive runs.
// - While locked, level writes, clear and copy are refused; all clear allowed.
// - Internal updates such as part life always get written.
// - Level and password stay writable whatever the write selection is.
// - Write selection and extended display restrictions take precedence.
// - Network restriction covers RS-485 access; panel covers the panel source.
// - Levels blocking panel writes disable easy-setting mode switching.
// - Contrast stays accessible under lock when a parameter unit is fitted.
`include "ppl_defines.svh"

module ppl_lock
  import ppl_pkg::*;
(
  input  wire logic       clk,              // Control clock, 25 MHz
  input  wire logic       srst,             // Synchronous reset, high
  input  wire logic       req_valid,        // Access or command request
  input  wire ppl_req_t   req,              // Request fields
  input  wire logic       running,          // Drive is running
  input  wire logic [1:0] param_write_select, // Write selection setting
  input  wire logic       ext_display_zero, // Extended display select is 0
  input  wire logic       param_unit_fitted, // External parameter unit present
  output ppl_resp_t       resp,             // Answer, one cycle after request
  output logic            all_clear_go,     // Pulse: clear every parameter
  output logic            locked,           // Password registered
  output logic            hard_locked,      // Five errors reached
  output logic            easy_switch_en,   // Easy-setting mode switch allowed
  output logic            panel_jog_en      // Panel jog operation allowed
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  ppl_state_t  state;
  logic [15:0] lock_restriction_level;
  logic [15:0] password;
  logic [2:0]  err_count;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Valid level encodings
  function automatic logic lvl_valid(input logic [15:0] v);
    return (v >= 16'h0001 && v <= `PPL_LVL_MAXLO) ||
           (v >= `PPL_LVL_MINHI && v <= `PPL_LVL_MAXHI) ||
           (v == `PPL_LVL_NONE);
  endfunction

  // Levels 101..106 count unlock errors
  function automatic logic lvl_counts(input logic [15:0] v);
    return v >= `PPL_LVL_MINHI && v <= `PPL_LVL_MAXHI;
  endfunction

  // Restriction digit 1..6, zero for no lock
  function automatic logic [2:0] lvl_digit(input logic [15:0] v);
    logic [15:0] d;
    d = lvl_counts(v) ? v - `PPL_LVL_HUND : v;
    return (v == `PPL_LVL_NONE) ? 3'h0 : d[2:0];
  endfunction

  // Password-level blocking of one source and direction
  function automatic logic lvl_blocks(input logic [2:0] dg, input ppl_src_t s,
                                      input logic w);
    logic pn;
    logic nt;
    pn = (s == SRC_PANEL);
    nt = (s == SRC_NET);
    case (dg)
      3'h1:    return w && (pn || nt);
      3'h2:    return w && pn;
      3'h3:    return w && nt;
      3'h4:    return pn || nt;
      3'h5:    return pn;
      3'h6:    return nt;
      default: return 1'b0;
    endcase
  endfunction

  // Write selection ban on ordinary parameters
  function automatic logic ws_blocks(input logic [1:0] ws, input logic run);
    return (ws == `PPL_WS_NEVER) || (ws == `PPL_WS_STOP && run);
  endfunction

  // ----------------------------------------------------------------
  // Request decision
  // ----------------------------------------------------------------
  logic [2:0]  digit;
  logic        is_locked;
  logic        grant;
  logic        uerr;
  logic [15:0] rd;
  logic        do_level;
  logic        do_reg;
  logic        do_unlock;
  logic        do_err;
  logic        do_all;

  assign digit     = lvl_digit(lock_restriction_level);
  assign is_locked = (state != ST_OPEN);

  // One decision per request; priorities follow the access kind
  always_comb begin
    grant     = 1'b0;
    uerr      = 1'b0;
    rd        = 16'h0000;
    do_level  = 1'b0;
    do_reg    = 1'b0;
    do_unlock = 1'b0;
    do_err    = 1'b0;
    do_all    = 1'b0;
    if (req_valid) begin
      case (req.op)
        OP_ALL_CLEAR: begin
          grant  = !running;
          do_all = !running;
        end
        OP_CLEAR, OP_COPY: begin
          grant = !is_locked;
        end
        OP_ACCESS: begin
          case (req.kind)
            K_LEVEL: begin
              // Needs extended display; write selection does not apply
              if (req.wr) begin
                grant    = ext_display_zero && !is_locked &&
                           lvl_valid(req.wdata);
                do_level = grant;
              end else begin
                grant = 1'b1;
                rd    = lock_restriction_level;
              end
            end
            K_PASS: begin
              if (!req.wr) begin
                grant = 1'b1;
                if (!is_locked)
                  rd = `PPL_PW_NONE;
                else if (lvl_counts(lock_restriction_level))
                  rd = {13'h0000, err_count};
                else
                  rd = 16'h0000;
              end else if (lock_restriction_level == `PPL_LVL_NONE) begin
                grant = 1'b0;
              end else if (state == ST_OPEN) begin
                grant  = req.wdata >= `PPL_PW_MIN &&
                         req.wdata <= `PPL_PW_MAX;
                do_reg = grant;
              end else if (state == ST_LOCKED &&
                           req.wdata == password) begin
                grant     = 1'b1;
                do_unlock = 1'b1;
              end else begin
                uerr   = 1'b1;
                do_err = (state == ST_LOCKED);
              end
            end
            K_CONTRAST: begin
              // Parameter unit keeps contrast reachable under lock
              grant = param_unit_fitted ||
                      !(is_locked && lvl_blocks(digit, req.src, req.wr));
              if (req.wr && req.src != SRC_INTERNAL &&
                  ws_blocks(param_write_select, running))
                grant = 1'b0;
            end
            default: begin
              // Ordinary parameter: outer bans first, then password level
              if (req.src == SRC_INTERNAL)
                grant = 1'b1;
              else if (req.wr && ws_blocks(param_write_select, running))
                grant = 1'b0;
              else if (!req.wr && req.ext && req.src == SRC_PANEL &&
                       !ext_display_zero)
                grant = 1'b0;
              else
                grant = !(is_locked &&
                          lvl_blocks(digit, req.src, req.wr));
            end
          endcase
        end
        default: grant = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Lock level register
  // ----------------------------------------------------------------
  // All clear returns the level to no lock
  always_ff @(posedge clk) begin
    if (srst || do_all)
      lock_restriction_level <= `PPL_LVL_NONE;
    else if (do_level)
      lock_restriction_level <= req.wdata;
  end

  // ----------------------------------------------------------------
  // Password store and lock state
  // ----------------------------------------------------------------
  // Only all clear leaves the hard state
  always_ff @(posedge clk) begin
    if (srst || do_all) begin
      state    <= ST_OPEN;
      password <= `PPL_PW_NONE;
    end else if (do_reg) begin
      state    <= ST_LOCKED;
      password <= req.wdata;
    end else if (do_unlock) begin
      state    <= ST_OPEN;
      password <= `PPL_PW_NONE;
    end else if (do_err && lvl_counts(lock_restriction_level) &&
                 err_count == `PPL_ERR_MAX - 3'h1) begin
      state    <= ST_HARD;
    end
  end

  // ----------------------------------------------------------------
  // Unlock error counter
  // ----------------------------------------------------------------
  // Levels 1..6 never count, so attempts there are unlimited
  always_ff @(posedge clk) begin
    if (srst || do_all || do_unlock)
      err_count <= 3'h0;
    else if (do_err && lvl_counts(lock_restriction_level) &&
             err_count != `PPL_ERR_MAX)
      err_count <= err_count + 3'h1;
  end

  // ----------------------------------------------------------------
  // Answers and status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      resp         <= '0;
      all_clear_go <= 1'b0;
    end else begin
      resp.valid      <= req_valid;
      resp.ok         <= grant;
      resp.unlock_err <= uerr;
      resp.rdata      <= grant ? rd : 16'h0000;
      all_clear_go    <= do_all;
    end
  end

  // Status follows the state one cycle late, like the answer
  always_ff @(posedge clk) begin
    if (srst) begin
      locked         <= 1'b0;
      hard_locked    <= 1'b0;
      easy_switch_en <= 1'b1;
      panel_jog_en   <= 1'b1;
    end else begin
      locked         <= is_locked;
      hard_locked    <= (state == ST_HARD);
      easy_switch_en <= !(is_locked && lvl_blocks(digit, SRC_PANEL, 1'b1));
      panel_jog_en   <= !(is_locked && param_unit_fitted &&
                          (digit == 3'h4 || digit == 3'h5));
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic lvl_wr_req;
  logic pw_wr_req;
  assign lvl_wr_req = req_valid && req.op == OP_ACCESS && req.kind == K_LEVEL && req.wr;
  assign pw_wr_req  = req_valid && req.op == OP_ACCESS && req.kind == K_PASS && req.wr;

  property p_reset_level;
    @(posedge clk) srst |=> lock_restriction_level == `PPL_LVL_NONE && !locked;
  endproperty
  a_reset_level: assert property (p_reset_level) else $error("level not none after reset");

  property p_net_write_l1;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ACCESS && req.kind == K_PARAM && req.src == SRC_NET &&
      req.wr && is_locked && digit == 3'h1 |=> resp.valid && !resp.ok;
  endproperty
  a_net_write_l1: assert property (p_net_write_l1) else $error("network write passed at level 1");

  property p_panel_read_l5;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ACCESS && req.kind == K_PARAM && req.src == SRC_PANEL &&
      !req.wr && is_locked && digit == 3'h5 |=> !resp.ok;
  endproperty
  a_panel_read_l5: assert property (p_panel_read_l5) else $error("panel read passed at level 5");

  property p_pw_hidden;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ACCESS && req.kind == K_PASS && !req.wr && is_locked
      |=> resp.rdata <= 16'h0005;
  endproperty
  a_pw_hidden: assert property (p_pw_hidden) else $error("password register leaked");

  property p_hard_stays;
    @(posedge clk) disable iff (srst)
      state == ST_HARD && !(req_valid && req.op == OP_ALL_CLEAR) |=> state == ST_HARD;
  endproperty
  a_hard_stays: assert property (p_hard_stays) else $error("hard lock released");

  property p_all_clear_run;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ALL_CLEAR && running |=> !all_clear_go && !resp.ok;
  endproperty
  a_all_clear_run: assert property (p_all_clear_run) else $error("all clear while running");

  property p_all_clear_rel;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ALL_CLEAR && !running
      |=> all_clear_go && state == ST_OPEN && err_count == 3'h0 ##1 !locked;
  endproperty
  a_all_clear_rel: assert property (p_all_clear_rel) else $error("all clear kept lock");

  property p_level_frozen;
    @(posedge clk) disable iff (srst)
      lvl_wr_req && is_locked && !(req.op == OP_ALL_CLEAR)
      |=> $stable(lock_restriction_level) && !resp.ok;
  endproperty
  a_level_frozen: assert property (p_level_frozen) else $error("level written while locked");

  property p_internal_ok;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ACCESS && req.kind == K_PARAM && req.src == SRC_INTERNAL
      |=> resp.ok;
  endproperty
  a_internal_ok: assert property (p_internal_ok) else $error("internal update refused");

  property p_unlock;
    @(posedge clk) disable iff (srst)
      pw_wr_req && state == ST_LOCKED && req.wdata == password
      |=> state == ST_OPEN && err_count == 3'h0 && resp.ok ##1 !locked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("correct password did not unlock");

  property p_err_sat;
    @(posedge clk) disable iff (srst) err_count <= `PPL_ERR_MAX;
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("error count above five");

  property p_ws_precedence;
    @(posedge clk) disable iff (srst)
      req_valid && req.op == OP_ACCESS && req.kind == K_PARAM && req.wr &&
      req.src != SRC_INTERNAL && param_write_select == `PPL_WS_NEVER |=> !resp.ok;
  endproperty
  a_ws_precedence: assert property (p_ws_precedence) else $error("write selection ignored");

  property p_easy_off;
    @(posedge clk) disable iff (srst)
      is_locked && digit == 3'h2 |=> !easy_switch_en;
  endproperty
  a_easy_off: assert property (p_easy_off) else $error("easy switch left on");

  c_register: cover property (@(posedge clk) disable iff (srst) $rose(locked));
  c_hard:     cover property (@(posedge clk) disable iff (srst) $rose(hard_locked));
  c_unlock:   cover property (@(posedge clk) disable iff (srst) $fell(locked));
  c_clear:    cover property (@(posedge clk) disable iff (srst) all_clear_go);

endmodule // ppl_lock

// ---- ppl_pkg.sv ----
// Types for the parameter password lock block
package ppl_pkg;
  typedef enum logic [1:0] {SRC_PANEL, SRC_NET, SRC_INTERNAL} ppl_src_t;
  typedef enum logic [1:0] {K_PARAM, K_LEVEL, K_PASS, K_CONTRAST} ppl_kind_t;
  typedef enum logic [1:0] {OP_ACCESS, OP_CLEAR, OP_ALL_CLEAR, OP_COPY} ppl_op_t;
  typedef enum logic [1:0] {ST_OPEN, ST_LOCKED, ST_HARD} ppl_state_t;
  typedef struct packed {
    ppl_op_t     op;
    ppl_kind_t   kind;
    ppl_src_t    src;
    logic        wr;
    logic        ext;
    logic [15:0] wdata;
  } ppl_req_t;
  typedef struct packed {
    logic        valid;
    logic        ok;
    logic        unlock_err;
    logic [15:0] rdata;
  } ppl_resp_t;
endpackage

// ---- tb_top.sv ----
// Self-checking bench for the parameter password lock
module tb_top
  import ppl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, srst, req_valid, running, ext_display_zero, param_unit_fitted;
  logic        ext_req = 1'b0; // Extended-mode flag carried by the next requests
  logic [1:0]  param_write_select;
  ppl_req_t    req;
  ppl_resp_t   resp, r;
  logic        all_clear_go, locked, hard_locked, easy_switch_en, panel_jog_en;
  int          fail_count, num_checks, cycles;
  // Allowed {panel rd, panel wr, net rd, net wr} per level digit 1..6
  logic [3:0]  allow [0:5] = '{4'hA, 4'hB, 4'hE, 4'h0, 4'h3, 4'hC};
  localparam logic [5:0] EASY = 6'h24; // Easy switch stays on at digits 3, 6

  ppl_lock ppl_lock_inst (.clk(clk), .srst(srst), .req_valid(req_valid), .req(req),
    .running(running), .param_write_select(param_write_select),
    .ext_display_zero(ext_display_zero), .param_unit_fitted(param_unit_fitted), .resp(resp),
    .all_clear_go(all_clear_go), .locked(locked), .hard_locked(hard_locked),
    .easy_switch_en(easy_switch_en), .panel_jog_en(panel_jog_en));
  ppl_host ppl_host_inst (.clk(clk), .resp(resp), .req_valid(req_valid), .req(req));

  // -----------------------------------------------------------------
  // Checking helpers
  // -----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Send one request and judge the grant bit
  task automatic go(ppl_op_t op, ppl_kind_t k, ppl_src_t s, logic wr, logic [15:0] wd,
                    logic ok);
    ppl_host_inst.xfer(op, k, s, wr, wd, ext_req, r);
    chk({14'h0, r.valid, r.ok}, {14'h0, 1'b1, ok});
  endtask

  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_reset();
    chk({12'h0, locked, hard_locked, easy_switch_en, panel_jog_en}, 16'h0003);
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b0, 16'h0000, 1'b1);
    chk(r.rdata, 16'h270F);
    go(OP_ACCESS, K_PASS, SRC_NET, 1'b0, 16'h0000, 1'b1);
    chk(r.rdata, 16'h270F);
  endtask

  // Out-of-range levels and password at no-lock are refused
  task automatic t_refuse();
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h0007, 1'b0);
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h0064, 1'b0);
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h006B, 1'b0);
    ext_display_zero = 1'b0;
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h0065, 1'b0);
    ext_display_zero = 1'b1;
    go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h04D2, 1'b0);
    chk({15'h0, r.unlock_err}, 16'h0000);
  endtask

  // Every lock level: lock, probe the access table, unlock
  task automatic t_levels();
    logic [15:0] lv;
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 6; i++) begin
        lv = 16'(i + 1 + j * 100);
        go(OP_ACCESS, K_LEVEL, SRC_NET, 1'b1, lv, 1'b1);
        go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h03E7, 1'b0);
        go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h270F, 1'b0);
        go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h03E8, 1'b1);
        go(OP_ACCESS, K_PASS, SRC_NET, 1'b0, 16'h0000, 1'b1);
        chk(r.rdata, 16'h0000);
        chk({14'h0, locked, easy_switch_en}, {14'h0, 1'b1, EASY[i]});
        go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h0003, 1'b0);
        go(OP_CLEAR, K_PARAM, SRC_PANEL, 1'b1, 16'h0000, 1'b0);
        go(OP_COPY, K_PARAM, SRC_PANEL, 1'b1, 16'h0000, 1'b0);
        go(OP_ACCESS, K_PARAM, SRC_PANEL, 1'b0, 16'h0000, allow[i][3]);
        go(OP_ACCESS, K_PARAM, SRC_PANEL, 1'b1, 16'h0001, allow[i][2]);
        go(OP_ACCESS, K_PARAM, SRC_NET, 1'b0, 16'h0000, allow[i][1]);
        go(OP_ACCESS, K_PARAM, SRC_NET, 1'b1, 16'h0001, allow[i][0]);
        go(OP_ACCESS, K_PARAM, SRC_INTERNAL, 1'b1, 16'h0002, 1'b1);
        param_unit_fitted = 1'b1;
        go(OP_ACCESS, K_CONTRAST, SRC_PANEL, 1'b1, 16'h0005, 1'b1);
        chk({15'h0, panel_jog_en}, {15'h0, !(i == 3 || i == 4)});
        param_unit_fitted = 1'b0;
        go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h03E8, 1'b1);
        chk({15'h0, r.unlock_err}, 16'h0000);
      end
    end
  endtask

  // Five wrong passwords harden the lock; only all clear frees it
  task automatic t_hard();
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h0065, 1'b1);
    go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h1388, 1'b1);
    // One error then a good unlock: the count must start again from zero
    go(OP_ACCESS, K_PASS, SRC_NET, 1'b1, 16'h1389, 1'b0);
    go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h1388, 1'b1);
    go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h1388, 1'b1);
    for (int e = 1; e < 7; e++) begin
      go(OP_ACCESS, K_PASS, SRC_NET, 1'b1, 16'h1389, 1'b0);
      chk({15'h0, r.unlock_err}, 16'h0001);
      go(OP_ACCESS, K_PASS, SRC_NET, 1'b0, 16'h0000, 1'b1);
      chk(r.rdata, (e > 5) ? 16'h0005 : 16'(e));
    end
    chk({15'h0, hard_locked}, 16'h0001);
    go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h1388, 1'b0);
    chk({15'h0, r.unlock_err}, 16'h0001);
    running = 1'b1;
    go(OP_ALL_CLEAR, K_PARAM, SRC_PANEL, 1'b1, 16'h0000, 1'b0);
    chk({15'h0, all_clear_go}, 16'h0000);
    running = 1'b0;
    go(OP_ALL_CLEAR, K_PARAM, SRC_PANEL, 1'b1, 16'h0000, 1'b1);
    chk({15'h0, all_clear_go}, 16'h0001);
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b0, 16'h0000, 1'b1);
    chk(r.rdata, 16'h270F);
    chk({14'h0, locked, hard_locked}, 16'h0000);
  endtask

  // Write selection refuses writes while unlocked and spares the lock registers
  task automatic t_select();
    param_write_select = 2'h1;
    go(OP_ACCESS, K_PARAM, SRC_PANEL, 1'b1, 16'h0001, 1'b0);
    go(OP_ACCESS, K_LEVEL, SRC_PANEL, 1'b1, 16'h0003, 1'b1);
    param_write_select = 2'h0;
    running = 1'b1;
    go(OP_ACCESS, K_PARAM, SRC_NET, 1'b1, 16'h0001, 1'b0);
    go(OP_ACCESS, K_PASS, SRC_PANEL, 1'b1, 16'h1F40, 1'b1);
    go(OP_ACCESS, K_PARAM, SRC_INTERNAL, 1'b1, 16'h0002, 1'b1);
    running = 1'b0;
    param_write_select = 2'h2;
    // Extended display hides extended parameters from the panel only
    ext_req = 1'b1;
    ext_display_zero = 1'b0;
    go(OP_ACCESS, K_PARAM, SRC_PANEL, 1'b0, 16'h0000, 1'b0);
    go(OP_ACCESS, K_PARAM, SRC_NET, 1'b0, 16'h0000, 1'b1);
    go(OP_ACCESS, K_PASS, SRC_NET, 1'b1, 16'h1F40, 1'b1);
    ext_display_zero = 1'b1;
    go(OP_ACCESS, K_PARAM, SRC_PANEL, 1'b0, 16'h0000, 1'b1);
    ext_req = 1'b0;
  endtask

  // -----------------------------------------------------------------
  // Clock, timeout and main sequence
  // -----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Whole run needs well under 3000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    srst = 1'b1;
    running = 1'b0;
    param_write_select = 2'h2;
    ext_display_zero = 1'b1;
    param_unit_fitted = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    srst = 1'b0;
    t_reset();
    t_refuse();
    t_levels();
    t_hard();
    t_select();
    report_and_stop();
  end
endmodule // tb_top
